// file: ldm_dimmer.sv
/*
  Global brightness path of a six-channel LED driver: source select, PWM input detector,
  sloper, dither with minimum-pulse skipping, and phase-shift/hybrid/current/direct drive.
  Assumes straps and the PWM input are asynchronous pins, control bits come from
  register logic on sys_clk, and that register logic resets the source select to 0 (pin).
*/
`timescale 1ns/1ns
module ldm_dimmer #(
  parameter int CLK_HZ = ldm_pkg::CLK_HZ
) (
  // Clock, reset, enable
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic                clk_en,
  // Resistor straps, sampled at initialization
  input  wire ldm_pkg::ldm_strap_t mode_strap,
  input  wire ldm_pkg::ldm_strap_t dimming_freq_strap,
  input  wire ldm_pkg::ldm_strap_t string_config_strap,
  // Brightness input pin
  input  wire logic                pwm_in,
  // Control from register logic
  input  wire ldm_pkg::ldm_ctrl_t  ctrl,
  // LED drive and status
  output logic [5:0]               led_out,
  output logic [15:0]              led_current,
  output logic [6:0]               i2c_target_addr,
  output ldm_pkg::ldm_mode_t       dimming_mode,
  output logic                     init_done
);
  import ldm_pkg::*;

  typedef struct packed {
    ldm_state_t    st;
    logic          done;
    logic [1:0]    icnt;
    logic [3:0]    s1_mode, s2_mode, s1_freq, s2_freq, s1_str, s2_str;
    logic          p1, p2, p3;
    ldm_mode_t     mode;
    logic [6:0]    addr;
    logic [2:0]    fcode, scode;
    logic [PW-1:0] cnt;
    logic [3:0]    frame;
    logic [PW-1:0] in_hi, in_per, acc_hi;
    logic          dbusy;
    logic [3:0]    dcnt;
    logic [PW:0]   drem;
    logic [PW-1:0] dper;
    logic [BW-1:0] dq, pwm_brt;
    logic [BW-1:0] tgt, cur, step;
    logic [23:0]   tick;
    logic [PW-1:0] onw, sacc;
    logic [7:0]    scnt;
    logic [5:0]    led;
    logic [BW-1:0] ilev;
  } ldm_st_t;

  ldm_st_t       s_reg, s_next;
  logic [PW-1:0] period, hdiff, onb, onx, sacc2;
  logic          wrap, rise, ext, dge;
  logic [PW:0]   drem2;
  logic [BW-1:0] src, duty, ilev, sdiff, ndiff, stp;
  logic [23:0]   tick_lim;
  logic [PW+15:0] prod;
  logic [2:0]    lvl;
  logic [3:0]    rev, idx, dv;
  logic [5:0]    mask, ch_on;
  logic [7:0]    slim;
  ldm_strap_t    ms, fs, ss;

  ldm_period_rom #(.CLK_HZ(CLK_HZ)) u_rom (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .code    (s_reg.fcode),
    .period  (period)
  );

  assign ms = s_reg.s2_mode;
  assign fs = s_reg.s2_freq;
  assign ss = s_reg.s2_str;

  assign wrap  = s_reg.cnt >= period - PW'(1);
  assign rise  = s_reg.p2 & ~s_reg.p3;
  assign hdiff = (s_reg.in_hi > s_reg.acc_hi) ? s_reg.in_hi - s_reg.acc_hi : s_reg.acc_hi - s_reg.in_hi;
  assign drem2 = {s_reg.drem[PW-1:0], 1'b0};
  assign dge   = drem2 >= {1'b0, s_reg.dper};

  assign src = ctrl.brightness_source_select ? ctrl.display_brightness_value : s_reg.pwm_brt;
  assign sdiff = (s_reg.tgt > s_reg.cur) ? s_reg.tgt - s_reg.cur : s_reg.cur - s_reg.tgt;
  assign ndiff = (src > s_reg.cur) ? src - s_reg.cur : s_reg.cur - src;
  // Decaying steps ease the approach to the target
  assign stp = !ctrl.smooth_curve_enable ? s_reg.step :
               ((sdiff >> SMOOTH_SHIFT) == '0) ? 16'h0001 : sdiff >> SMOOTH_SHIFT;
  assign tick_lim = 24'(SLOPE_MS[ctrl.slope_sel] * (CLK_HZ / 1000) / (1 << SLOPE_STEPS_LOG));

  // Hybrid keeps current at the threshold level while PWM covers the low range
  always_comb begin
    duty = FULL_BRT;
    ilev = FULL_BRT;
    case (s_reg.mode)
      DM_PHASE: begin
        duty = s_reg.cur;
      end
      DM_HYBRID: begin
        if (ctrl.hyb_thr_en && s_reg.cur < HYB_THR) begin
          duty = s_reg.cur << 3;
          ilev = HYB_THR;
        end else begin
          ilev = s_reg.cur;
        end
      end
      DM_CURRENT: begin
        ilev = s_reg.cur;
      end
      default: begin
        duty = FULL_BRT;
      end
    endcase
  end

  assign prod = duty * period;
  assign onb  = (duty == FULL_BRT) ? period : prod[PW+15:16];
  assign lvl  = (ctrl.dither_sel > DITHER_MAX) ? 3'h0 : ctrl.dither_sel[2:0];
  // Bit-reversed frame index spreads the lengthened pulses evenly
  assign rev  = {s_reg.frame[0], s_reg.frame[1], s_reg.frame[2], s_reg.frame[3]};
  assign idx  = rev >> (3'h4 - lvl);
  assign dv   = prod[15:12] >> (3'h4 - lvl);
  assign ext  = (lvl != 3'h0) && (idx < dv) && (onb < period);
  assign onx  = onb + PW'(ext);
  assign sacc2 = s_reg.sacc + onx;
  assign slim = (8'h01 << s_reg.fcode) - 8'h01;
  assign mask = (s_reg.scode < 3'h5) ? 6'h3F >> s_reg.scode : 6'h3F;

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic [2:0]     grp;
    logic [BW-1:0]  frac;
    logic [PW+15:0] offp;
    logic [PW-1:0]  off, pos;
    always_comb begin
      case (s_reg.scode)
        3'h5:    grp = 3'(i / 2);
        3'h6:    grp = 3'(i / 3);
        3'h7:    grp = 3'h0;
        default: grp = 3'(i);
      endcase
    end
    assign frac = 16'(grp * RECIP[s_reg.scode]);
    assign offp = period * frac;
    assign off  = offp[PW+15:16] + PW'(offp[15]);
    assign pos  = (s_reg.cnt >= off) ? s_reg.cnt - off : s_reg.cnt + period - off;
    assign ch_on[i] = mask[i] & ((s_reg.mode == DM_DIRECT) ? s_reg.p2 :
                                 (s_reg.mode == DM_CURRENT) ? 1'b1 :
                                 (pos < s_reg.onw));
  end

  always_comb begin
    s_next = s_reg;
    s_next.s1_mode = mode_strap;
    s_next.s2_mode = s_reg.s1_mode;
    s_next.s1_freq = dimming_freq_strap;
    s_next.s2_freq = s_reg.s1_freq;
    s_next.s1_str  = string_config_strap;
    s_next.s2_str  = s_reg.s1_str;
    s_next.p1 = pwm_in;
    s_next.p2 = s_reg.p1;
    s_next.p3 = s_reg.p2;
    s_next.led = 6'h00;
    case (s_reg.st)
      ST_SYNC: begin
        s_next.icnt = s_reg.icnt + 2'h1;
        if (s_reg.icnt == 2'(INIT_CYC - 1)) begin
          s_next.mode  = ms.valid ? ldm_mode_t'(4'h1 << ms.code[1:0]) : DM_PHASE;
          s_next.addr  = (!ms.valid || ms.code[2]) ? ADDR_LOW : ADDR_HIGH;
          s_next.fcode = fs.valid ? fs.code : FREQ_DEFAULT;
          s_next.scode = ss.valid ? ss.code : STRING_DEFAULT;
          s_next.st    = ST_LATCH;
        end
      end
      ST_LATCH: begin
        s_next.st   = ST_RUN;
        s_next.done = 1'b1;
      end
      ST_RUN: begin
        // Input detector: count high time and period between rising edges
        s_next.in_per = (&s_reg.in_per) ? s_reg.in_per : s_reg.in_per + PW'(1);
        if (s_reg.p2 && !(&s_reg.in_hi)) begin
          s_next.in_hi = s_reg.in_hi + PW'(1);
        end
        if (s_reg.dbusy) begin
          s_next.drem = dge ? drem2 - {1'b0, s_reg.dper} : drem2;
          s_next.dq   = {s_reg.dq[14:0], dge};
          s_next.dcnt = s_reg.dcnt + 4'h1;
          if (s_reg.dcnt == 4'hF) begin
            s_next.dbusy   = 1'b0;
            s_next.pwm_brt = {s_reg.dq[14:0], dge};
          end
        end
        if (rise) begin
          s_next.in_per = PW'(1);
          s_next.in_hi  = PW'(1);
          // Small on-time jitter from slow board edges is ignored
          if (hdiff > PW'(HYST_CYC)) begin
            s_next.acc_hi = s_reg.in_hi;
            if (s_reg.in_hi >= s_reg.in_per) begin
              s_next.pwm_brt = FULL_BRT;
              s_next.dbusy   = 1'b0;
            end else begin
              s_next.dbusy = 1'b1;
              s_next.drem  = {1'b0, s_reg.in_hi};
              s_next.dper  = s_reg.in_per;
              s_next.dcnt  = 4'h0;
              s_next.dq    = '0;
            end
          end
        end
        // Sloper
        s_next.tgt = src;
        if (src != s_reg.tgt) begin
          s_next.step = ((ndiff >> SLOPE_STEPS_LOG) == '0) ? 16'h0001 : ndiff >> SLOPE_STEPS_LOG;
          s_next.tick = '0;
        end else if (ctrl.slope_sel == 3'h0) begin
          s_next.cur = s_reg.tgt;
        end else if (s_reg.tick >= tick_lim - 24'h1) begin
          s_next.tick = '0;
          if (sdiff <= stp) begin
            s_next.cur = s_reg.tgt;
          end else if (s_reg.tgt > s_reg.cur) begin
            s_next.cur = s_reg.cur + stp;
          end else begin
            s_next.cur = s_reg.cur - stp;
          end
        end else begin
          s_next.tick = s_reg.tick + 24'h1;
        end
        // Period counter and per-period pulse width
        if (wrap) begin
          s_next.cnt   = '0;
          s_next.frame = s_reg.frame + 4'h1;
          if (onx != '0 && onx < PW'(MINP_CYC)) begin
            if (sacc2 >= PW'(MINP_CYC) || s_reg.scnt >= slim) begin
              s_next.onw  = PW'(MINP_CYC);
              s_next.sacc = (sacc2 >= PW'(MINP_CYC)) ? sacc2 - PW'(MINP_CYC) : '0;
              s_next.scnt = 8'h00;
            end else begin
              s_next.onw  = '0;
              s_next.sacc = sacc2;
              s_next.scnt = s_reg.scnt + 8'h01;
            end
          end else begin
            s_next.onw  = onx;
            s_next.sacc = '0;
            s_next.scnt = 8'h00;
          end
        end else begin
          s_next.cnt = s_reg.cnt + PW'(1);
        end
        s_next.led  = ch_on;
        s_next.ilev = ilev;
      end
      default: begin
        s_next.st = ST_SYNC;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg      <= '0;
      s_reg.st   <= ST_SYNC;
      s_reg.mode <= DM_PHASE;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign led_out         = s_reg.led;
  assign led_current     = s_reg.ilev;
  assign i2c_target_addr = s_reg.addr;
  assign dimming_mode    = s_reg.mode;
  assign init_done       = s_reg.done;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_run_en;
    clk_en && s_reg.st == ST_RUN;
  endsequence
  sequence s_wrap;
    s_run_en ##0 wrap;
  endsequence
  sequence s_latched;
    $rose(s_reg.st == ST_LATCH);
  endsequence

  property p_period_wrap;
    s_wrap |=> s_reg.cnt == '0;
  endproperty
  a_period_wrap: assert property (p_period_wrap) else $error("period counter did not restart");

  property p_addr_latch;
    s_latched |-> s_reg.addr == ((!$past(s_reg.s2_mode[3]) || $past(s_reg.s2_mode[2])) ? ADDR_LOW : ADDR_HIGH);
  endproperty
  a_addr_latch: assert property (p_addr_latch) else $error("target address wrong after strap latch");

  property p_freq_latch;
    s_latched |-> s_reg.fcode == ($past(s_reg.s2_freq[3]) ? $past(s_reg.s2_freq[2:0]) : FREQ_DEFAULT);
  endproperty
  a_freq_latch: assert property (p_freq_latch) else $error("frequency code wrong after strap latch");

  property p_direct;
    (s_run_en ##0 s_reg.mode == DM_DIRECT) |=> led_out == ($past(mask) & {6{$past(s_reg.p2)}});
  endproperty
  a_direct: assert property (p_direct) else $error("direct mode output does not follow input");

  property p_hyst;
    (s_run_en ##0 (rise && hdiff <= PW'(HYST_CYC))) |=> $stable(s_reg.acc_hi);
  endproperty
  a_hyst: assert property (p_hyst) else $error("on-time accepted inside hysteresis");

  property p_noslope;
    (s_run_en ##0 (ctrl.slope_sel == 3'h0 && src == s_reg.tgt)) |=> s_reg.cur == $past(s_reg.tgt);
  endproperty
  a_noslope: assert property (p_noslope) else $error("brightness not applied at once");

  property p_nodither;
    (s_wrap ##0 (lvl == 3'h0 && onb >= PW'(MINP_CYC))) |=> s_reg.onw == $past(onb);
  endproperty
  a_nodither: assert property (p_nodither) else $error("pulse lengthened with dither off");

  property p_floor;
    s_reg.st == ST_RUN |-> s_reg.scnt <= slim;
  endproperty
  a_floor: assert property (p_floor) else $error("too many pulses skipped in a row");

  property p_minpulse;
    (s_wrap ##0 (onx != '0 && onx < PW'(MINP_CYC))) |=> (s_reg.onw == '0 || s_reg.onw == PW'(MINP_CYC));
  endproperty
  a_minpulse: assert property (p_minpulse) else $error("pulse shorter than minimum emitted");

endmodule

// file: ldm_dimmer_tb.sv
/*
  Self-checking bench of the brightness dimmer: straps, widths, phase, dither, modes, pin, skipping, slope.
  Assumes the dimmer built with a lowered CLK_HZ so that periods stay short.
*/
`timescale 1ns/1ns
module ldm_dimmer_tb;
  import ldm_pkg::*;
  localparam int CLK = 2_000_000;
  localparam int PER = CLK / FREQ_HZ[7];
  localparam int TMO = 100000;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       clk_en = 1'b1;
  ldm_strap_t mode_strap = 4'h8;
  ldm_strap_t dimming_freq_strap = 4'hF;
  ldm_strap_t string_config_strap = 4'hF;
  logic       pwm_in;
  ldm_ctrl_t  ctrl = '0;
  logic [5:0] led_out;
  logic [15:0] led_current;
  logic [6:0] i2c_target_addr;
  ldm_mode_t  dimming_mode;
  logic       init_done;
  logic       host_en = 1'b0;
  logic [15:0] hi_cyc = 16'h0064;
  logic [15:0] per_cyc = 16'h00C8;
  int         failures = 0;
  int         tests_run = 0;
  int         cyc_cnt = 0;
  logic [31:0] c;
  logic [31:0] prod;
  int          k;
  logic [15:0] bt [3] = '{16'h8000, 16'h4000, 16'hFFFF};

  always #25 sys_clk = ~sys_clk;

  ldm_dimmer #(.CLK_HZ(CLK)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .mode_strap(mode_strap),
    .dimming_freq_strap(dimming_freq_strap), .string_config_strap(string_config_strap), .pwm_in(pwm_in),
    .ctrl(ctrl), .led_out(led_out), .led_current(led_current), .i2c_target_addr(i2c_target_addr),
    .dimming_mode(dimming_mode), .init_done(init_done));

  ldm_host_model host (.sys_clk(sys_clk), .rst_n(rst_n), .enable(host_en), .hi_cyc(hi_cyc),
    .per_cyc(per_cyc), .pwm_out(pwm_in));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc_cnt++;
    if (cyc_cnt == TMO) begin
      failures++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic do_reset(input logic [3:0] m, input logic [3:0] s);
    @(negedge sys_clk);
    rst_n = 1'b0;
    mode_strap = m;
    string_config_strap = s;
    repeat (3) @(negedge sys_clk);
    chk("rst_mode", 32'(DM_PHASE), 32'(dimming_mode));
    rst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk("init_early", 32'h0, 32'(init_done));
    @(negedge sys_clk);
    chk("init_done", 32'h1, 32'(init_done));
  endtask

  // Starts at a rising edge of channel 0 so that whole periods are summed
  task automatic hi_count(input int n, output logic [31:0] cnt);
    int w;
    w = 0;
    while (led_out[0] !== 1'b0 && w < 400) begin @(negedge sys_clk); w++; end
    while (led_out[0] !== 1'b1 && w < 400) begin @(negedge sys_clk); w++; end
    cnt = 32'h0;
    repeat (n) begin
      cnt = cnt + 32'(led_out[0]);
      @(negedge sys_clk);
    end
  endtask

  task automatic set_b(input logic [15:0] b, input int settle);
    ctrl.display_brightness_value = b;
    repeat (settle) @(negedge sys_clk);
  endtask

  initial begin
    for (int i = 0; i < 9; i++) begin
      dimming_freq_strap = (i < 8) ? 4'hF : 4'h0;
      do_reset({i < 8, 3'(i)}, 4'hF);
      chk("addr", (i < 8 && i[2] == 1'b0) ? 32'(ADDR_HIGH) : 32'(ADDR_LOW), 32'(i2c_target_addr));
      chk("mode", (i < 8) ? 32'h1 << i[1:0] : 32'(DM_PHASE), 32'(dimming_mode));
    end
    dimming_freq_strap = 4'hF;
    $display("test straps done");
    do_reset(4'h8, 4'hF);
    ctrl.brightness_source_select = 1'b1;
    for (int i = 0; i < 3; i++) begin
      set_b(bt[i], 3 * PER);
      hi_count(PER, c);
      chk("width", (bt[i] == FULL_BRT) ? PER : (32'(bt[i]) * PER) >> 16, c);
    end
    set_b(16'h5555, 2 * PER);
    prod = 32'h5555 * PER;
    for (int n = 0; n < 6; n++) begin
      k = (n < 5) ? n : 0;
      ctrl.dither_sel = (n < 5) ? 4'(n) : 4'hF;
      repeat (2 * PER) @(negedge sys_clk);
      hi_count(PER << k, c);
      chk("dither_sum", ((prod >> 16) << k) + 32'(prod[15:0] >> (16 - k)), c);
    end
    ctrl.dither_sel = 4'h0;
    $display("test width and dither done");
    for (int s = 0; s < 2; s++) begin
      do_reset(4'h8, {1'b1, 3'(s)});
      set_b(16'h4000, 3 * PER);
      hi_count(1, c);
      k = 1;
      while (led_out[1] !== 1'b1 && k < PER) begin @(negedge sys_clk); k++; end
      chk("phase_delay", PER / GRP_N[s], 32'(k));
    end
    $display("test phase done");
    do_reset(4'h9, 4'hF);
    ctrl.hyb_thr_en = 1'b1;
    set_b(16'h1000, 3 * PER);
    chk("hyb_low_cur", 32'(HYB_THR), 32'(led_current));
    hi_count(PER, c);
    chk("hyb_low_duty", (32'h8000 * PER) >> 16, c);
    set_b(16'h8000, 3 * PER);
    chk("hyb_high_cur", 32'h8000, 32'(led_current));
    hi_count(PER, c);
    chk("hyb_high_duty", PER, c);
    ctrl.hyb_thr_en = 1'b0;
    set_b(16'h1000, 3 * PER);
    chk("hyb_zero_cur", 32'h1000, 32'(led_current));
    do_reset(4'hA, 4'hF);
    set_b(16'h3000, 10);
    chk("cur_level", 32'h3000, 32'(led_current));
    chk("cur_on", 32'h3F, 32'(led_out));
    $display("test hybrid and current done");
    do_reset(4'hB, 4'hA);
    host_en = 1'b1;
    for (int r = 0; r < 2; r++) begin
      @(posedge pwm_in);
      repeat (5) @(negedge sys_clk);
      chk("direct_on", 32'h0F, 32'(led_out));
      @(negedge pwm_in);
      repeat (5) @(negedge sys_clk);
      chk("direct_off", 32'h0, 32'(led_out));
    end
    $display("test direct done");
    do_reset(4'h8, 4'hF);
    ctrl.brightness_source_select = 1'b0;
    per_cyc = 16'd1000;
    for (int i = 0; i < 3; i++) begin
      hi_cyc = (i == 0) ? 16'd500 : (i == 1) ? 16'd560 : 16'd700;
      repeat (4000) @(negedge sys_clk);
      hi_count(PER, c);
      chk("pin_width", ((((i == 2) ? 700 : 500) * 65536 / 1000) * PER) >> 16, c);
    end
    host_en = 1'b0;
    $display("test pin done");
    ctrl.brightness_source_select = 1'b1;
    set_b(16'h0400, 2 * PER);
    k = 0;
    while (led_out[0] !== 1'b0 && k < PER) begin @(negedge sys_clk); k++; end
    repeat (4) begin
      k = 0;
      while (led_out[0] !== 1'b1 && k < 200 * PER) begin @(negedge sys_clk); k++; end
      chk("skip_gap", 32'h1, 32'(k <= 128 * PER));
      k = 0;
      while (led_out[0] === 1'b1 && k < PER) begin @(negedge sys_clk); k++; end
      chk("min_pulse", 32'h1, 32'(k >= MINP_CYC));
    end
    $display("test skip done");
    do_reset(4'hA, 4'hF);
    for (int sm = 0; sm < 2; sm++) begin
      ctrl.slope_sel = 3'h0;
      set_b(16'h0000, 10);
      ctrl.slope_sel = 3'h1;
      ctrl.smooth_curve_enable = sm[0];
      set_b(16'h8000, 1000);
      if (sm == 0)
        chk("slope_lin", 32'h1, 32'(led_current > 16'h0000 && led_current < 16'h0300));
      else
        chk("slope_smooth", 32'h1, 32'(led_current > 16'h0300 && led_current < 16'h8000));
    end
    $display("test slope done");
    print_verdict();
  end
endmodule

// file: ldm_host_model.sv
/*
  Host side of the brightness pin: a PWM source with programmable on-time and period.
  Assumes the bench sets the on-time and period off the rising edge of sys_clk;
  new settings take effect at the next period start.
*/
`timescale 1ns/1ns
module ldm_host_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Waveform settings
  input  wire logic        enable,
  input  wire logic [15:0] hi_cyc,
  input  wire logic [15:0] per_cyc,
  // Pin
  output logic             pwm_out
);
  logic [15:0] cnt_reg;
  logic [15:0] hi_reg;
  logic [15:0] per_reg;

  // A disabled host leaves the pin low; with no rising edge the device keeps its last pin brightness
  // Settings load only at a period boundary, so a change never splits a pulse
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 16'h0000;
      hi_reg  <= 16'h0000;
      per_reg <= 16'h0001;
      pwm_out <= 1'b0;
    end else begin
      if (cnt_reg >= per_reg - 16'h0001) begin
        cnt_reg <= 16'h0000;
        hi_reg  <= hi_cyc;
        per_reg <= per_cyc;
      end else begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
      pwm_out <= enable && (cnt_reg < hi_reg);
    end
  end
endmodule

// file: ldm_period_rom.sv
/*
  Period table: LED PWM period in system clocks for each dimming frequency code.
  Assumes the code is stable for a cycle before the period is used; output is registered.
*/
`timescale 1ns/1ns
module ldm_period_rom #(
  parameter int CLK_HZ = ldm_pkg::CLK_HZ
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire logic                   clk_en,
  // Lookup
  input  wire logic [2:0]             code,
  output logic      [ldm_pkg::PW-1:0] period
);
  import ldm_pkg::*;

  // Steps per period equal clocks per period, one step per clock
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      period <= '0;
    end else if (clk_en) begin
      period <= PW'(CLK_HZ / FREQ_HZ[code]);
    end
  end

endmodule

// file: ldm_pkg.sv
/*
  Shared constants and types of the LED brightness PWM dimmer.
  Assumes a single 20 MHz system clock; all times below are converted to cycles of it.
*/
package ldm_pkg;

  localparam int CLK_HZ  = 20_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int PW      = 18;
  localparam int BW      = 16;
  localparam int NCH     = 6;

  // Dimming frequency per strap code; period is CLK_HZ / frequency
  localparam int FREQ_HZ [8] = '{152, 305, 610, 1221, 2441, 4883, 9766, 19531};
  localparam logic [2:0] FREQ_DEFAULT   = 3'h1;
  localparam logic [2:0] STRING_DEFAULT = 3'h0;

  localparam logic [6:0] ADDR_LOW  = 7'h2A;
  localparam logic [6:0] ADDR_HIGH = 7'h2B;

  localparam int HYST_NS  = 6400;
  localparam int HYST_CYC = HYST_NS * CLK_MHZ / 1000;
  localparam int MINP_NS  = 200;
  localparam int MINP_CYC = (MINP_NS * CLK_MHZ + 999) / 1000;

  localparam logic [BW-1:0] HYB_THR  = 16'h2000;
  localparam logic [BW-1:0] FULL_BRT = 16'hFFFF;

  // Slope durations in ms per select code; code 0 means no slope
  localparam int SLOPE_MS [8]   = '{0, 50, 100, 150, 200, 300, 500, 1000};
  localparam logic [2:0] SLOPE_DEFAULT = 3'h4;
  localparam int SLOPE_STEPS_LOG = 8;
  localparam int SMOOTH_SHIFT    = 5;

  localparam int INIT_CYC = 3;
  localparam logic [3:0] DITHER_MAX = 4'h4;

  // Groups in use per string code and the phase step in 1/65536 of a period
  localparam int GRP_N [8] = '{6, 5, 4, 3, 2, 3, 2, 1};
  localparam int RECIP [8] = '{65536/6, 65536/5, 65536/4, 65536/3, 65536/2, 65536/3, 65536/2, 0};

  typedef enum logic [3:0] {
    DM_PHASE   = 4'h1,
    DM_HYBRID  = 4'h2,
    DM_CURRENT = 4'h4,
    DM_DIRECT  = 4'h8
  } ldm_mode_t;

  typedef enum logic [2:0] {
    ST_SYNC  = 3'h1,
    ST_LATCH = 3'h2,
    ST_RUN   = 3'h4
  } ldm_state_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] code;
  } ldm_strap_t;

  typedef struct packed {
    logic          brightness_source_select;
    logic [BW-1:0] display_brightness_value;
    logic [2:0]    slope_sel;
    logic          smooth_curve_enable;
    logic [3:0]    dither_sel;
    logic          hyb_thr_en;
  } ldm_ctrl_t;

endpackage
